// File: pkg/ijs_pkg.sv
// Purpose: Shared constants and types for the ink jet dot serializer.
// Assumes: 40 MHz system clock, two logic boards, two chained 9-dot heads.
// Notes: Head link timing counts cycles of the separate head link clock.
package ijs_pkg;
  localparam int HEADS = 2;
  localparam int DOTS_PER_HEAD = 9;
  localparam int DOTS_PER_CYCLE = 18;
  localparam int SYS_CLK_HZ = 40_000_000;
  localparam int POC_TIME_MS = 1000;
  localparam int POC_CYCLES = SYS_CLK_HZ / 1000 * POC_TIME_MS;
  localparam int POC_W = 26;
  localparam int OSC_DIV_DEFAULT = 400;
  localparam int OSC_W = 16;
  localparam int FIRE_LINK_CYC = 4;
  localparam int FIFO_DEPTH = 4;
  localparam int MSG_COLS_DEFAULT = 8;
  localparam int COL_W = 8;
  localparam int SW_W = 8;
  localparam int SW_DELAY_LSB = 0;
  localparam int SW_DELAY_W = 6;
  localparam int SW_ADDR_LSB = 6;
  localparam int SW_ADDR_W = 2;
  localparam int FONT_W = 18;
  localparam int FONT_ODD_LSB = 9;
  localparam int FONT_EVEN_LSB = 0;
  localparam logic [4:0] LAST_DOT = 5'(DOTS_PER_CYCLE - 1);
  localparam logic [4:0] LAST_SYNC_DOT = 5'(DOTS_PER_CYCLE - 1);
  localparam logic [2:0] LAST_FIRE_CYC = 3'(FIRE_LINK_CYC - 1);
  // Synchronised pin positions
  localparam int PIN_ENC = 0;
  localparam int PIN_SENS0 = 1;
  localparam int PIN_RS232 = 3;
  localparam int PIN_RS422 = 4;
  localparam int PIN_W = 5;

  typedef struct packed {
    logic [DOTS_PER_HEAD-1:0] second_head;
    logic [DOTS_PER_HEAD-1:0] first_head;
  } ijs_dot_word_t;

  typedef struct packed {
    logic clk_p;
    logic clk_n;
    logic data_p;
    logic data_n;
    logic fire_p;
    logic fire_n;
  } ijs_head_pins_t;

  localparam ijs_head_pins_t PINS_IDLE = 6'b01_01_01;

  typedef enum logic [1:0] {B_IDLE, B_DELAY, B_PRINT} ijs_board_st_t;
  typedef enum logic [1:0] {L_IDLE, L_LOW, L_HIGH, L_FIRE} ijs_link_st_t;

  typedef struct packed {
    ijs_board_st_t st;
    logic [SW_DELAY_W-1:0] cnt;
    logic [COL_W-1:0] col;
    logic odd_done;
    logic pending;
    logic [DOTS_PER_HEAD-1:0] dots;
    logic [SW_W-1:0] sw;
    logic [1:0] lamp;
  } ijs_board_t;
endpackage : ijs_pkg

// File: verilog/ijs_dot_serializer.sv
// Purpose: Print data path: logic boards, parallel load, FIFO, head serializer.
// Assumes: head_clk is a free running link clock unrelated to sys_clk.
// Notes: Static jumpers and switches are taken when the power-on clear ends.
// What this block does
// - Load strobe captures both boards when data pending
// - Trigger pulse accompanies each parallel load
// - Fire pulse follows exactly 18 shift clocks
// - Captured word leaves one dot per clock
// - Clock, fire, data leave as differential pairs
// - Encoder or jumpered oscillator paces; 18-dot sync
// - One-second power-on clear resets the print path
// - Jumper selects RS-232 or RS-422 terminal data
// - Each board runs alone, one head each
// - Sensor starts delay count before data flows
// - Columns delivered as odd then even sections
// - Odd and even never in one transfer
// - Switches give address, delay; lamps show status
// - First nine dots pass on to second head
// - One fire pulse drives both heads together

module ijs_fifo #(
  parameter int W = 18,
  parameter int D = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [W-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] count;
  } ijs_fifo_state_t;

  ijs_fifo_state_t f_ff;
  ijs_fifo_state_t nxt_f;
  logic push;
  logic pop;

  assign wr_ready = (f_ff.count != CW'(D));
  assign rd_valid = (f_ff.count != '0);
  assign rd_data = f_ff.mem[f_ff.rp];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;

  always_comb begin
    nxt_f = f_ff;
    if (clr) begin
      nxt_f.wp = '0;
      nxt_f.rp = '0;
      nxt_f.count = '0;
    end else begin
      if (push) begin
        nxt_f.mem[f_ff.wp] = wr_data;
        nxt_f.wp = (f_ff.wp == PW'(D - 1)) ? '0 : f_ff.wp + 1'b1;
      end
      if (pop) begin
        nxt_f.rp = (f_ff.rp == PW'(D - 1)) ? '0 : f_ff.rp + 1'b1;
      end
      if (push && !pop) begin
        nxt_f.count = f_ff.count + 1'b1;
      end else if (pop && !push) begin
        nxt_f.count = f_ff.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      f_ff <= '0;
    end else begin
      f_ff <= nxt_f;
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
    (push && !pop && !clr) |=> (f_ff.count == $past(f_ff.count) + 1'b1))
    else $error("fifo count did not follow a write");
endmodule : ijs_fifo

module ijs_dot_serializer
  import ijs_pkg::*;
#(
  parameter int POC_CYC = ijs_pkg::POC_CYCLES,
  parameter int OSC_DIV = ijs_pkg::OSC_DIV_DEFAULT,
  parameter int MSG_COLS = ijs_pkg::MSG_COLS_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic head_clk,
  input wire logic encoder_in,
  input wire logic [ijs_pkg::HEADS-1:0] sensor_in,
  input wire logic rs232_in,
  input wire logic rs422_in,
  input wire logic osc_jumper,
  input wire logic rs232_jumper,
  input wire logic [ijs_pkg::HEADS-1:0][ijs_pkg::SW_W-1:0] board_switch,
  input wire logic [ijs_pkg::HEADS-1:0][ijs_pkg::FONT_W-1:0] font_col,
  output logic [ijs_pkg::HEADS-1:0][ijs_pkg::COL_W-1:0] font_addr,
  output logic [ijs_pkg::HEADS-1:0][ijs_pkg::SW_ADDR_W-1:0] board_addr,
  output logic [ijs_pkg::HEADS-1:0][1:0] status_lamp,
  output logic term_to_boards,
  output logic dot_sync,
  output logic power_on_clear_n,
  output logic parallel_load_strobe,
  output logic print_trigger,
  output ijs_pkg::ijs_head_pins_t head_pins
);
  import ijs_pkg::*;

  typedef struct packed {
    logic [2:0][PIN_W-1:0] pin_sy;
    logic [PIN_W-1:0] pin_lvl;
    logic [POC_W-1:0] poc_cnt;
    logic poc_n;
    logic osc_sel;
    logic rs232_sel;
    logic [OSC_W-1:0] osc_cnt;
    logic [4:0] sync_cnt;
    logic dot_sync;
    logic term;
    ijs_board_t [HEADS-1:0] board;
    logic strobe;
    logic trigger;
    ijs_dot_word_t word;
    logic busy;
    logic req;
    logic [2:0] ack_sy;
    logic ack_seen;
    ijs_dot_word_t xfer;
  } ijs_sys_t;

  typedef struct packed {
    logic [2:0] req_sy;
    logic [2:0] clr_sy;
    logic [2:0] en_sy;
    logic req_seen;
    ijs_link_st_t st;
    logic [4:0] bitcnt;
    logic [DOTS_PER_CYCLE-1:0] sh;
    logic [2:0] firecnt;
    logic ack;
    ijs_head_pins_t pins;
  } ijs_link_t;

  ijs_sys_t s_ff;
  ijs_sys_t nxt_s;
  ijs_link_t l_ff;
  ijs_link_t nxt_l;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_rd_ready;
  ijs_dot_word_t fifo_rd_data;

  // Queue between capture and head link; the link drains one word per print cycle
  ijs_fifo #(.W(DOTS_PER_CYCLE), .D(FIFO_DEPTH)) u_fifo (
    .clk(sys_clk),
    .arst_n(arst_n),
    .clr(clk_en && !s_ff.poc_n),
    .wr_valid(clk_en && s_ff.strobe),
    .wr_ready(fifo_wr_ready),
    .wr_data(s_ff.word),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_rd_ready),
    .rd_data(fifo_rd_data)
  );

  assign fifo_rd_ready = clk_en && s_ff.poc_n && !s_ff.busy;

  always_comb begin
    logic line_tick;
    logic osc_tick;
    logic sens_rise;
    logic any_pend;
    logic [SW_DELAY_W-1:0] delay;
    line_tick = 1'b0;
    osc_tick = 1'b0;
    sens_rise = 1'b0;
    any_pend = 1'b0;
    delay = '0;
    nxt_s = s_ff;
    if (clk_en) begin
      nxt_s.pin_sy[0] = {rs422_in, rs232_in, sensor_in, encoder_in};
      nxt_s.pin_sy[1] = s_ff.pin_sy[0];
      nxt_s.pin_sy[2] = s_ff.pin_sy[1];
      for (int i = 0; i < PIN_W; i++) begin
        if (s_ff.pin_sy[1][i] == s_ff.pin_sy[2][i]) begin
          nxt_s.pin_lvl[i] = s_ff.pin_sy[2][i];
        end
      end
      nxt_s.ack_sy = {s_ff.ack_sy[1:0], l_ff.ack};
      nxt_s.strobe = 1'b0;
      nxt_s.trigger = 1'b0;
      nxt_s.dot_sync = 1'b0;
      if (!s_ff.poc_n) begin
        // Whole print path held clear until the count expires
        nxt_s.poc_cnt = s_ff.poc_cnt + 1'b1;
        nxt_s.board = '0;
        nxt_s.busy = 1'b0;
        nxt_s.ack_seen = s_ff.ack_sy[2];
        nxt_s.osc_cnt = '0;
        nxt_s.sync_cnt = '0;
        if (s_ff.poc_cnt == POC_W'(POC_CYC - 1)) begin
          nxt_s.poc_n = 1'b1;
          nxt_s.osc_sel = osc_jumper;
          nxt_s.rs232_sel = rs232_jumper;
          for (int b = 0; b < HEADS; b++) begin
            nxt_s.board[b].sw = board_switch[b];
          end
        end
      end else begin
        osc_tick = (s_ff.osc_cnt == OSC_W'(OSC_DIV - 1));
        nxt_s.osc_cnt = osc_tick ? '0 : s_ff.osc_cnt + 1'b1;
        // Fixed-rate oscillator stands in for the encoder on constant lines
        line_tick = s_ff.osc_sel ? osc_tick
                                 : (nxt_s.pin_lvl[PIN_ENC] && !s_ff.pin_lvl[PIN_ENC]);
        if (line_tick) begin
          nxt_s.dot_sync = (s_ff.sync_cnt == LAST_SYNC_DOT);
          nxt_s.sync_cnt = nxt_s.dot_sync ? '0 : s_ff.sync_cnt + 1'b1;
        end
        // RS-232 receiver output already carries the same sense as RS-422
        nxt_s.term = s_ff.rs232_sel ? s_ff.pin_lvl[PIN_RS232] : s_ff.pin_lvl[PIN_RS422];
        for (int b = 0; b < HEADS; b++) begin
          // Boards share only the line tick; each owns its own head
          sens_rise = nxt_s.pin_lvl[PIN_SENS0 + b] && !s_ff.pin_lvl[PIN_SENS0 + b];
          delay = s_ff.board[b].sw[SW_DELAY_LSB +: SW_DELAY_W];
          nxt_s.board[b].lamp = {s_ff.board[b].st == B_PRINT, s_ff.board[b].st == B_DELAY};
          case (s_ff.board[b].st)
            B_IDLE: begin
              if (sens_rise) begin
                nxt_s.board[b].cnt = '0;
                nxt_s.board[b].col = '0;
                nxt_s.board[b].odd_done = 1'b0;
                nxt_s.board[b].st = (delay == '0) ? B_PRINT : B_DELAY;
              end
            end
            B_DELAY: begin
              if (line_tick) begin
                nxt_s.board[b].cnt = s_ff.board[b].cnt + 1'b1;
                if (s_ff.board[b].cnt + 1'b1 >= delay) begin
                  nxt_s.board[b].st = B_PRINT;
                end
              end
            end
            B_PRINT: begin
              if (line_tick && !s_ff.board[b].pending) begin
                // One section per transfer, odd first then even
                nxt_s.board[b].pending = 1'b1;
                nxt_s.board[b].dots = s_ff.board[b].odd_done
                  ? font_col[b][FONT_EVEN_LSB +: DOTS_PER_HEAD]
                  : font_col[b][FONT_ODD_LSB +: DOTS_PER_HEAD];
                nxt_s.board[b].odd_done = !s_ff.board[b].odd_done;
                if (s_ff.board[b].odd_done) begin
                  nxt_s.board[b].col = s_ff.board[b].col + 1'b1;
                  if (s_ff.board[b].col == COL_W'(MSG_COLS - 1)) begin
                    nxt_s.board[b].st = B_IDLE;
                  end
                end
              end
            end
            default: begin
              nxt_s.board[b].st = B_IDLE;
            end
          endcase
          any_pend = any_pend || s_ff.board[b].pending;
        end
        // Capture stalls while the queue is full, so boards wait with data pending
        if (any_pend && fifo_wr_ready && !s_ff.strobe) begin
          nxt_s.strobe = 1'b1;
          nxt_s.trigger = 1'b1;
          // Board 1 feeds the far head, whose dots must go out first
          nxt_s.word.second_head = s_ff.board[1].pending ? s_ff.board[1].dots : '0;
          nxt_s.word.first_head = s_ff.board[0].pending ? s_ff.board[0].dots : '0;
          for (int b = 0; b < HEADS; b++) begin
            if (s_ff.board[b].pending) begin
              nxt_s.board[b].pending = 1'b0;
            end
          end
        end
        if (s_ff.busy) begin
          if (s_ff.ack_sy[1] == s_ff.ack_sy[2] && s_ff.ack_sy[2] != s_ff.ack_seen) begin
            nxt_s.busy = 1'b0;
            nxt_s.ack_seen = s_ff.ack_sy[2];
          end
        end else if (fifo_rd_valid) begin
          // Only one word in flight until its fire pulse ends
          nxt_s.xfer = fifo_rd_data;
          nxt_s.req = !s_ff.req;
          nxt_s.busy = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    nxt_l = l_ff;
    nxt_l.req_sy = {l_ff.req_sy[1:0], s_ff.req};
    nxt_l.clr_sy = {l_ff.clr_sy[1:0], !s_ff.poc_n};
    nxt_l.en_sy = {l_ff.en_sy[1:0], clk_en};
    if (l_ff.clr_sy[1] && l_ff.clr_sy[2]) begin
      nxt_l.st = L_IDLE;
      nxt_l.pins = PINS_IDLE;
      nxt_l.req_seen = l_ff.req_sy[2];
    end else if (l_ff.en_sy[2]) begin
      case (l_ff.st)
        L_IDLE: begin
          if (l_ff.req_sy[1] == l_ff.req_sy[2] && l_ff.req_sy[2] != l_ff.req_seen) begin
            // Word is held stable by the sender until acknowledged
            nxt_l.req_seen = l_ff.req_sy[2];
            nxt_l.sh = s_ff.xfer;
            nxt_l.bitcnt = '0;
            nxt_l.pins.data_p = s_ff.xfer[DOTS_PER_CYCLE-1];
            nxt_l.pins.data_n = !s_ff.xfer[DOTS_PER_CYCLE-1];
            nxt_l.st = L_LOW;
          end
        end
        L_LOW: begin
          nxt_l.pins.clk_p = 1'b1;
          nxt_l.pins.clk_n = 1'b0;
          nxt_l.st = L_HIGH;
        end
        L_HIGH: begin
          nxt_l.pins.clk_p = 1'b0;
          nxt_l.pins.clk_n = 1'b1;
          nxt_l.bitcnt = l_ff.bitcnt + 1'b1;
          nxt_l.sh = {l_ff.sh[DOTS_PER_CYCLE-2:0], 1'b0};
          if (l_ff.bitcnt == LAST_DOT) begin
            // One fire for both chained heads after the eighteenth clock
            nxt_l.pins.fire_p = 1'b1;
            nxt_l.pins.fire_n = 1'b0;
            nxt_l.firecnt = '0;
            nxt_l.st = L_FIRE;
          end else begin
            nxt_l.pins.data_p = l_ff.sh[DOTS_PER_CYCLE-2];
            nxt_l.pins.data_n = !l_ff.sh[DOTS_PER_CYCLE-2];
            nxt_l.st = L_LOW;
          end
        end
        L_FIRE: begin
          nxt_l.firecnt = l_ff.firecnt + 1'b1;
          if (l_ff.firecnt == LAST_FIRE_CYC) begin
            // Solenoid pulse width is timed by the head boards themselves
            nxt_l.pins = PINS_IDLE;
            nxt_l.ack = !l_ff.ack;
            nxt_l.st = L_IDLE;
          end
        end
        default: begin
          nxt_l.st = L_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge head_clk or negedge arst_n) begin
    if (!arst_n) begin
      l_ff <= '{pins: PINS_IDLE, st: L_IDLE, default: '0};
    end else begin
      l_ff <= nxt_l;
    end
  end

  for (genvar b = 0; b < HEADS; b++) begin : g_board_out
    assign font_addr[b] = s_ff.board[b].col;
    assign board_addr[b] = s_ff.board[b].sw[SW_ADDR_LSB +: SW_ADDR_W];
    assign status_lamp[b] = s_ff.board[b].lamp;
  end

  assign term_to_boards = s_ff.term;
  assign dot_sync = s_ff.dot_sync;
  assign power_on_clear_n = s_ff.poc_n;
  assign parallel_load_strobe = s_ff.strobe;
  assign print_trigger = s_ff.trigger;
  assign head_pins = l_ff.pins;

  load_needs_data_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(s_ff.strobe) |-> $past(s_ff.board[0].pending || s_ff.board[1].pending))
    else $error("load strobe without pending data");
  trigger_with_load_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    s_ff.strobe == s_ff.trigger)
    else $error("trigger and load strobe differ");
  load_hold_off_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_ff.req != $past(s_ff.req)) |-> $past(!s_ff.busy) ##0 s_ff.busy)
    else $error("new word sent while previous cycle busy");
  clear_quiet_sys_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !s_ff.poc_n |=> !s_ff.strobe && !s_ff.busy)
    else $error("print path active during power-on clear");
  delay_reached_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_ff.board[0].st == B_PRINT && $past(s_ff.board[0].st) == B_DELAY)
      |-> ($past(s_ff.board[0].cnt) + 1'b1 >= s_ff.board[0].sw[SW_DELAY_LSB +: SW_DELAY_W]))
    else $error("printing started before delay count");
  section_alternate_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (s_ff.board[0].pending && !$past(s_ff.board[0].pending))
      |-> (s_ff.board[0].odd_done != $past(s_ff.board[0].odd_done)))
    else $error("odd and even sections not alternating");
  fire_after_dots_a: assert property (@(posedge head_clk)
    disable iff (!arst_n || l_ff.clr_sy[2])
    $rose(l_ff.pins.fire_p) |-> (l_ff.bitcnt == 5'd18) && !l_ff.pins.clk_p)
    else $error("fire pulse not after eighteen shift clocks");
  fire_width_a: assert property (@(posedge head_clk)
    disable iff (!arst_n || l_ff.clr_sy[2] || !l_ff.en_sy[2])
    $rose(l_ff.pins.fire_p) |-> l_ff.pins.fire_p[*4] ##1 !l_ff.pins.fire_p)
    else $error("fire pulse width wrong");
  diff_pairs_a: assert property (@(posedge head_clk) disable iff (!arst_n)
    (l_ff.pins.clk_p != l_ff.pins.clk_n) && (l_ff.pins.fire_p != l_ff.pins.fire_n)
      && (l_ff.pins.data_p != l_ff.pins.data_n))
    else $error("differential pair not complementary");
  clear_quiet_link_a: assert property (@(posedge head_clk) disable iff (!arst_n)
    (l_ff.clr_sy[1] && l_ff.clr_sy[2]) |=> !l_ff.pins.clk_p && !l_ff.pins.fire_p)
    else $error("head driven during power-on clear");
endmodule : ijs_dot_serializer

// File: verification/ijs_head_chain.sv
// Purpose: Behavioural chain of two 9-dot head driver boards.
// Assumes: Pins are sampled mid-cycle, on the falling edge of the head link clock.
// Notes: Solenoid drive width is set on the board itself and not timed here.
module ijs_head_chain (
  input wire logic head_clk,
  input wire ijs_pkg::ijs_head_pins_t pins,
  output ijs_pkg::ijs_dot_word_t fired,
  output int fire_cnt,
  output int bad_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  import ijs_pkg::*;
  ijs_head_pins_t prev = PINS_IDLE;
  logic [DOTS_PER_CYCLE-1:0] chain = '0;
  int clk_cnt = 0;
  initial begin
    fired = '0;
    fire_cnt = 0;
    bad_cnt = 0;
  end
  always @(negedge head_clk) begin
    // Each pair must stay complementary
    if (pins.clk_n !== ~pins.clk_p || pins.data_n !== ~pins.data_p) bad_cnt++;
    if (pins.fire_n !== ~pins.fire_p) bad_cnt++;
    if (pins.clk_p && !prev.clk_p) begin
      // Overflow of the first head walks on into the second
      chain = {chain[DOTS_PER_CYCLE-2:0], pins.data_p};
      clk_cnt++;
      if (pins.fire_p) bad_cnt++;
    end
    if (pins.fire_p && !prev.fire_p) begin
      if (clk_cnt != DOTS_PER_CYCLE) bad_cnt++;
      clk_cnt = 0;
      // One latch edge serves both heads; set bits get their own drive
      fired = chain;
      fire_cnt++;
    end
    prev = pins;
  end
endmodule : ijs_head_chain

// File: verification/tb_ijs_dot_serializer.sv
// Purpose: Self-checking bench for the ink jet dot serializer.
// Assumes: Short power-on clear, oscillator divide of 5, four-column messages.
// Notes: Every font section holds a set dot, so an empty head half means no data.
module tb_ijs_dot_serializer;
  timeunit 1ns;
  timeprecision 100ps;
  import ijs_pkg::*;
  localparam int POC = 20;
  localparam int COLS = 4;
  logic sys_clk = 0;
  logic head_clk = 0;
  logic arst_n = 0;
  logic clk_en = 1;
  logic enc = 0;
  logic [1:0] sens = '0;
  logic r232 = 0;
  logic r422 = 0;
  logic osc_j = 0;
  logic r232_j = 0;
  logic [1:0][SW_W-1:0] sw = {8'h80, 8'h43};
  logic [1:0][FONT_W-1:0] font = '0;
  logic [1:0][COL_W-1:0] faddr;
  logic [1:0][1:0] baddr;
  logic [1:0][1:0] lamp;
  logic term, dsync, pocn, strobe, trig;
  ijs_head_pins_t pins;
  ijs_dot_word_t fired;
  int fire_cnt, bad_cnt, loads, ticks, syncs, maxout, frz;
  logic dsync_q = 0;
  int err_total = 0;
  int comparisons = 0;
  logic [FONT_W-1:0] rom [2][COLS];
  logic [DOTS_PER_HEAD-1:0] q [2][$];

  always #12.5 sys_clk = ~sys_clk;
  // Offset start keeps the link clock out of phase with the system clock
  initial begin
    #3.3;
    forever #7.5 head_clk = ~head_clk;
  end

  ijs_dot_serializer #(.POC_CYC(POC), .OSC_DIV(5), .MSG_COLS(COLS)) u_dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(clk_en), .head_clk(head_clk),
    .encoder_in(enc), .sensor_in(sens), .rs232_in(r232), .rs422_in(r422),
    .osc_jumper(osc_j), .rs232_jumper(r232_j), .board_switch(sw), .font_col(font),
    .font_addr(faddr), .board_addr(baddr), .status_lamp(lamp), .term_to_boards(term),
    .dot_sync(dsync), .power_on_clear_n(pocn), .parallel_load_strobe(strobe),
    .print_trigger(trig), .head_pins(pins));

  ijs_head_chain u_heads (.head_clk(head_clk), .pins(pins), .fired(fired),
    .fire_cnt(fire_cnt), .bad_cnt(bad_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("counts: comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  // Font answers the column address like a lookup table
  always @(negedge sys_clk) begin
    font[0] <= rom[0][faddr[0] % COLS];
    font[1] <= rom[1][faddr[1] % COLS];
  end

  always @(negedge sys_clk) begin
    if (strobe === 1'b1) begin
      loads++;
      check(trig, 1'b1);
    end
    // Count rises only, so a pulse held by a frozen clock enable counts once
    if (dsync === 1'b1 && dsync_q !== 1'b1) syncs++;
    dsync_q = dsync;
    if (loads - fire_cnt > maxout) maxout = loads - fire_cnt;
  end

  // Each fire must carry the next expected section of each board
  always @(fire_cnt) begin
    logic [DOTS_PER_HEAD-1:0] h;
    // Let the fired word settle past the count update of the same step
    #1;
    for (int b = 0; b < 2; b++) begin
      h = b ? fired.second_head : fired.first_head;
      if (h !== '0 && q[b].size() == 0) check(h, 0);
      else if (h !== '0) check(h, q[b].pop_front());
    end
  end

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      enc = 1;
      r232 = 1'($urandom);
      r422 = 1'($urandom);
      repeat (3) @(negedge sys_clk);
      enc = 0;
      repeat (2) @(negedge sys_clk);
      ticks++;
      check(term, r232_j ? r232 : r422);
    end
  endtask : tick

  task automatic start(input int b);
    for (int c = 0; c < COLS; c++) begin
      q[b].push_back(rom[b][c][FONT_ODD_LSB +: DOTS_PER_HEAD]);
      q[b].push_back(rom[b][c][FONT_EVEN_LSB +: DOTS_PER_HEAD]);
    end
    @(negedge sys_clk);
    sens[b] = 1;
    repeat (5) @(negedge sys_clk);
    sens[b] = 0;
  endtask : start

  task automatic drain();
    int n;
    n = 0;
    while (q[0].size() + q[1].size() > 0 && n < 300) begin
      tick(1);
      n++;
    end
    if (n == 300) begin
      check(q[0].size() + q[1].size(), 0);
      summarize();
    end
    repeat (10) @(negedge sys_clk);
  endtask : drain

  task automatic do_reset();
    int n;
    @(negedge sys_clk);
    arst_n = 0;
    repeat (20) @(negedge sys_clk);
    check(pocn, 1'b0);
    check(strobe, 1'b0);
    check(pins, PINS_IDLE);
    arst_n = 1;
    n = 0;
    while (pocn !== 1'b1 && n < POC + 10) begin
      check(pins, PINS_IDLE);
      @(negedge sys_clk);
      n++;
    end
    check(n >= POC - 1 && n <= POC + 2, 1);
    if (n >= POC + 10) summarize();
    @(negedge sys_clk);
    check(baddr, {sw[1][7:6], sw[0][7:6]});
    ticks = 0;
    syncs = 0;
  endtask : do_reset

  initial begin
    void'($urandom(26));
    loads = 0;
    maxout = 0;
    for (int b = 0; b < 2; b++) begin
      for (int c = 0; c < COLS; c++) rom[b][c] = FONT_W'($urandom) | 18'h20100;
    end
    do_reset();
    $display("test reset done");
    // Board 0 waits three ticks of delay, board 1 stays idle meanwhile
    start(0);
    tick(2);
    check(lamp[0], 2'h1);
    check(lamp[1], 2'h0);
    check(loads, 0);
    drain();
    check(syncs, ticks / DOTS_PER_CYCLE);
    $display("test delay done");
    // Both boards at once fill the FIFO while the link is slower than the ticks
    for (int i = 0; i < 3; i++) begin
      start(0);
      tick($urandom_range(0, 2));
      start(1);
      drain();
    end
    check(maxout >= FIFO_DEPTH, 1);
    check(maxout <= FIFO_DEPTH + 1, 1);
    check(loads, fire_cnt);
    $display("test both boards done");
    // Mid-run reset with oscillator pacing and the other terminal line
    osc_j = 1;
    r232_j = 1;
    do_reset();
    repeat (400) @(negedge sys_clk);
    check(syncs >= 3 && syncs <= 5, 1);
    // Clock enable low must freeze the oscillator and the dot sync count
    clk_en = 0;
    @(negedge sys_clk);
    frz = syncs;
    repeat (100) @(negedge sys_clk);
    check(syncs, frz);
    clk_en = 1;
    tick(4);
    check(bad_cnt, 0);
    $display("test oscillator done");
    summarize();
  end
endmodule : tb_ijs_dot_serializer
